// File: rtl/sarrd_pkg.sv
// Purpose: shared constants for the serial converter readout link
// Assumes: one system clock at 10 MHz, link clock sampled as a plain input
// Notes:   all counts are in link-clock falling edges unless named otherwise
package sarrd_pkg;
  localparam int unsigned RES_BITS      = 12;   // result width
  localparam int unsigned LEAD_ZEROS    = 4;    // falling edges carrying zero
  localparam int unsigned CONV_EDGES    = 16;   // link cycles per conversion
  localparam int unsigned ACQ_CYCLES    = 3;    // acquire_phase length
  localparam int unsigned CONVERT_CYCLES = 13;  // convert_phase length
  localparam int unsigned CNT_W         = 5;
  localparam logic [11:0] POS_FULL      = 12'h07FF;
  localparam logic [11:0] NEG_FULL      = 12'h0800;
  localparam int unsigned CODE_STEPS    = 4096; // one step is 2*vref/4096
  // link clock period the host makes, in ns, and its half period in clk_i cycles
  localparam int unsigned SYS_CLK_NS    = 100;
  localparam int unsigned LINK_CLK_NS   = 800;
  localparam int unsigned HALF_DIV      = LINK_CLK_NS / (2 * SYS_CLK_NS);
  localparam logic [4:0]  CNT_LAST      = 5'h0010;
  localparam logic [4:0]  CNT_CONV      = 5'h0004;
  typedef enum logic [1:0] {SARRD_OFF, SARRD_ACQ, SARRD_CONV} sarrd_phase_t;
endpackage

// File: rtl/sarrd_link_if.sv
// Purpose: three-wire link between the converter end and the host end
// Assumes: result pin is three-state; enable is active low
// Notes:   data always carries the bit register; nothing resolves it from data_oe_n
`timescale 1ns/10ps
interface sarrd_link_if;
  logic frame_n;     // frame select, active low, from host
  logic sclk;        // shift clock from host
  logic data;        // result bit from device
  logic data_oe_n;   // low while device drives the result pin
  modport dev  (input frame_n, input sclk, output data, output data_oe_n);
  modport host (output frame_n, output sclk, input data, input data_oe_n);
endinterface

// File: rtl/sarrd_sync.sv
// Purpose: two-flop synchroniser for one pin, with edge flags
// Assumes: input comes from outside the clk_i domain
// Notes:   edge flags read the second flop and a third history flop only
`timescale 1ns/10ps
module sarrd_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic rst_val_i,
  // pin and outputs
  input  wire logic pin_i,
  output logic      lvl_o,
  output logic      rise_o,
  output logic      fall_o
);
  import sarrd_pkg::*;
  logic s1_r, s2_r, s3_r;
  logic s1_nxt, s2_nxt, s3_nxt;
  // shift chain next values
  always_comb begin
    s1_nxt = pin_i;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end
  // register chain; reset to the pin's idle level so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_r <= rst_val_i;
      s2_r <= rst_val_i;
      s3_r <= rst_val_i;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end
  // level and edges from the settled flops
  assign lvl_o  = s2_r;
  assign rise_o = s2_r & ~s3_r;
  assign fall_o = ~s2_r & s3_r;
endmodule // sarrd_sync

// File: rtl/sarrd_dev.sv
// Purpose: converter end: frames, phases and streams results on the link
// Assumes: host makes frame select and shift clock; sample arrives in parallel
// Notes:   the analog core is modelled by sampling sample_i at each conversion start
// Overview of operation
// - a conversion spans sixteen shift-clock cycles
// - host may end frame early
// - input sampled when a conversion starts
// - result shifted out most significant first
// - output bits belong to current conversion
// - open frame starts next conversion immediately
// - host captures bits on rising edges
// - result is twelve-bit two's complement code
// - one code step is 2*vref/4096
// - frame falls to start, rises to end
// - result pin floats while frame high
// - first three cycles are acquisition
// - next thirteen cycles convert and output
// - four leading zeros then twelve bits
// - re-acquire after each sixteenth rising edge
// - frame falls, clock high: wait falling edge
// - frame falls, clock low: counts as edge
// - simultaneous fall enters acquisition
// - active while frame low, powered down otherwise
// - early frame rise aborts and floats output
// - output bits change on falling edges
`timescale 1ns/10ps
module sarrd_dev (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  // link
  sarrd_link_if.dev                 link,
  // user side: analog stand-in and status
  input  wire logic [11:0]          sample_i,
  output logic                      active_o,
  output sarrd_pkg::sarrd_phase_t   phase_o,
  output logic [11:0]               held_code_o
);
  import sarrd_pkg::*;

  // synchronised pins and sequencer state
  logic                fr_lvl;      // synced frame select, high while closed
  logic                fr_fall;     // frame select fell
  logic                ck_lvl;      // synced shift clock level
  logic                ck_fall;     // shift clock fell
  logic [CNT_W-1:0]    cnt_r;       // falling edges seen in this conversion
  logic [CNT_W-1:0]    cnt_nxt;
  logic [11:0]         code_r;      // sampled code of the running conversion
  logic [11:0]         code_nxt;
  logic                bit_r;       // bit on the result pin
  logic                bit_nxt;
  sarrd_phase_t        ph_r;        // acquire or convert phase
  sarrd_phase_t        ph_nxt;
  logic                fall_ev;     // one effective shift-clock falling edge
  logic                frame_off;   // frame closed and not just opening
  logic                conv_begin;  // this falling edge opens a conversion

  // next falling edge opens a conversion: frame just opened or sixteen edges done
  function automatic logic starts_conv(input logic [CNT_W-1:0] cnt);
    return (cnt == '0) || (cnt == CNT_LAST);
  endfunction

  // bit shown after falling edge cnt+1: zero on the leading edges, then msb down
  function automatic logic edge_bit(input logic [11:0]      code,
                                    input logic [CNT_W-1:0] cnt);
    int idx;
    idx = int'(RES_BITS) - 1 - (int'(cnt) - int'(LEAD_ZEROS));
    if (cnt < CNT_CONV || idx < 0) begin
      return 1'b0;
    end
    return code[idx];
  endfunction

  // pin synchronisers
  sarrd_sync u_fr (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b1),
    .pin_i    (link.frame_n),
    .lvl_o    (fr_lvl),
    .rise_o   (),
    .fall_o   (fr_fall)
  );
  sarrd_sync u_ck (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .rst_val_i(1'b1),
    .pin_i    (link.sclk),
    .lvl_o    (ck_lvl),
    .rise_o   (),
    .fall_o   (ck_fall)
  );

  // a falling frame with clock low counts as the first falling edge
  // with clock high we wait for the real fall
  assign fall_ev = (fr_fall & ~ck_lvl) | (~fr_lvl & ~fr_fall & ck_fall);

  // frame closed: the whole sequencer idles; a frame that is just opening is not closed
  assign frame_off  = fr_lvl & ~fr_fall;
  // a conversion opens on the first edge of a frame or after sixteen edges
  assign conv_begin = fall_ev & starts_conv(cnt_r);

  // edge counter next value: cleared while the frame is closed
  always_comb begin
    cnt_nxt = cnt_r;
    if (frame_off) begin
      cnt_nxt = '0;
    end else if (conv_begin) begin
      cnt_nxt = 5'h01;
    end else if (fall_ev) begin
      cnt_nxt = cnt_r + 5'h01;                            // sixteen edges a conversion
    end
  end

  // edge counter register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // sampled code: taken as a conversion opens, kept until the next one opens
  always_comb begin
    code_nxt = code_r;
    if (conv_begin) begin
      code_nxt = sample_i;
    end
  end

  // sampled code register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      code_r <= 12'h0000;
    end else begin
      code_r <= code_nxt;
    end
  end

  // phase next value: acquire for three edges, then convert for thirteen
  always_comb begin
    ph_nxt = ph_r;
    if (frame_off) begin
      ph_nxt = SARRD_OFF;
    end else if (conv_begin) begin
      ph_nxt = SARRD_ACQ;                                 // acquire_phase
    end else if (fall_ev && (cnt_r + 5'h01 == CNT_CONV)) begin
      ph_nxt = SARRD_CONV;                                // convert_phase
    end
  end

  // phase register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ph_r <= SARRD_OFF;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  // output bit next value: changes on an effective falling edge, cleared while the frame is closed
  always_comb begin
    bit_nxt = bit_r;
    if (frame_off || conv_begin) begin
      bit_nxt = 1'b0;                                     // first leading zero
    end else if (fall_ev) begin
      bit_nxt = edge_bit(code_r, cnt_r);
    end
  end

  // output bit register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bit_r <= 1'b0;
    end else begin
      bit_r <= bit_nxt;
    end
  end

  // timing note: a new bit reaches the pin three clk_i after the host's clock
  // falls (two pin flops and the bit register), so a host dividing clk_i by
  // less than eight per link period would see the bit after its rising edge;
  // the result is never buffered, a closed frame throws the conversion away

  // pin drive: enable low only inside a frame
  assign link.data      = bit_r;
  assign link.data_oe_n = fr_lvl;
  assign active_o       = ~fr_lvl;
  assign phase_o        = ph_r;
  assign held_code_o    = code_r;
endmodule // sarrd_dev

// File: rtl/sarrd_host.sv
// Purpose: host end: makes frame select and shift clock, gathers results
// Assumes: shift clock derived from clk_i by a divider; bits taken on rises
// Notes:   nbits_i of 1 to 11 short-cycles the frame; cont_i keeps a full twelve-bit frame open
`timescale 1ns/10ps
module sarrd_host (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // link
  sarrd_link_if.host       link,
  // user request
  input  wire logic        start_i,
  input  wire logic        cont_i,
  input  wire logic [3:0]  nbits_i,
  output logic             busy_o,
  // user result
  output logic [11:0]      result_o,
  output logic             result_vld_o
);
  import sarrd_pkg::*;
  typedef enum logic [1:0] {SH_IDLE, SH_RUN, SH_END} sarrd_hst_t;

  sarrd_hst_t  st_r, st_nxt;
  logic [7:0]  div_r, div_nxt;
  logic        sclk_r, sclk_nxt;
  logic        fr_r, fr_nxt;
  logic [4:0]  rcnt_r, rcnt_nxt;
  logic [11:0] sh_r, sh_nxt, res_r, res_nxt;
  logic        vld_r, vld_nxt;
  logic        d1_r, d2_r;
  logic [3:0]  want_r, want_nxt;
  logic [1:0]  take_r, take_nxt;       // capture pending, delayed two clocks
  logic [1:0]  last_r, last_nxt;       // pending capture is the last wanted bit
  logic        tick;

  // divider tick every half link period
  assign tick = (div_r == 8'(HALF_DIV - 1));

  // host sequencer next state
  always_comb begin
    st_nxt = st_r; div_nxt = tick ? 8'h00 : div_r + 8'h01;
    sclk_nxt = sclk_r; fr_nxt = fr_r; rcnt_nxt = rcnt_r;
    sh_nxt = sh_r; res_nxt = res_r; vld_nxt = 1'b0; want_nxt = want_r;
    take_nxt = {take_r[0], 1'b0};
    last_nxt = {last_r[0], 1'b0};
    case (st_r)
      SH_IDLE: begin
        sclk_nxt = 1'b1;
        if (start_i && tick) begin
          fr_nxt = 1'b0;                        // open frame with clock high
          rcnt_nxt = '0;
          want_nxt = (nbits_i == 4'h0 || nbits_i > 4'hC) ? 4'hC : nbits_i;
          st_nxt = SH_RUN;
        end
      end
      SH_RUN: if (tick) begin
        sclk_nxt = ~sclk_r;
        if (!sclk_r) begin
          // rising edge: mark the bit; it reaches d2_r two clocks later
          rcnt_nxt = rcnt_r + 5'h01;
          take_nxt[0] = (rcnt_r >= 5'(LEAD_ZEROS));
          last_nxt[0] = (rcnt_r == 5'(LEAD_ZEROS) + 5'(want_r) - 5'h01);
          if (last_nxt[0]) begin
            if (want_r != 4'hC || !cont_i) st_nxt = SH_END; // short cycle, or end of a single frame
          end
          if (rcnt_r == 5'(CONV_EDGES - 1)) rcnt_nxt = '0;   // full 16 cycles
        end
      end
      SH_END: if (tick) begin
        fr_nxt = 1'b1;                          // close frame
        sclk_nxt = 1'b1;
        st_nxt = SH_IDLE;
      end
      default: st_nxt = SH_IDLE;
    endcase
    // delayed capture: the bit crossed the two pin flops since the rise
    if (take_r[1]) begin
      sh_nxt = {sh_r[10:0], d2_r};
      if (last_r[1]) begin
        res_nxt = {sh_r[10:0], d2_r} << (4'hC - want_r);
        vld_nxt = 1'b1;
      end
    end
  end

  // host registers, data pin through two flops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= SH_IDLE; div_r <= 8'h00; sclk_r <= 1'b1; fr_r <= 1'b1;
      rcnt_r <= '0; sh_r <= 12'h0000; res_r <= 12'h0000; vld_r <= 1'b0;
      want_r <= 4'hC; d1_r <= 1'b0; d2_r <= 1'b0;
      take_r <= 2'h0;
      last_r <= 2'h0;
    end else begin
      st_r <= st_nxt; div_r <= div_nxt; sclk_r <= sclk_nxt; fr_r <= fr_nxt;
      rcnt_r <= rcnt_nxt; sh_r <= sh_nxt; res_r <= res_nxt; vld_r <= vld_nxt;
      want_r <= want_nxt; d1_r <= link.data; d2_r <= d1_r;
      take_r <= take_nxt;
      last_r <= last_nxt;
    end
  end

  assign link.sclk    = sclk_r;
  assign link.frame_n = fr_r;
  assign busy_o       = (st_r != SH_IDLE);
  assign result_o     = res_r;
  assign result_vld_o = vld_r;
endmodule // sarrd_host

// File: sim/sarrd_monitor.sv
// Purpose: checker on the three link wires between host and converter
// Assumes: one clk_i domain samples every wire
// Notes:   rise_cnt_r counts shift-clock rises within each conversion
`timescale 1ns/10ps
module sarrd_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // link wires
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic data,
  input wire logic data_oe_n
);
  logic [3:0] rise_cnt_r;
  logic [3:0] rise_cnt_nxt;
  logic       sclk_r;
  // next rise count, cleared while the frame is closed
  always_comb begin
    rise_cnt_nxt = frame_n ? 4'h0 : rise_cnt_r + 4'(sclk && !sclk_r);
  end
  // register the count and the clock history
  always_ff @(posedge clk_i) begin
    sclk_r     <= sys_rst_i ? 1'b1 : sclk;
    rise_cnt_r <= sys_rst_i ? 4'h0 : rise_cnt_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  oe_float_a: assert property (frame_n [*4] |-> data_oe_n)
    else $error("result pin driven outside a frame");
  oe_drive_a: assert property (!frame_n [*5] |-> !data_oe_n)
    else $error("result pin not driven in a frame");
  lead_zero_a: assert property ($rose(sclk) && !frame_n && rise_cnt_r < 4'h4 |-> !data)
    else $error("leading bit not zero");
  bit_on_fall_a: assert property ($changed(data) && !data_oe_n && $past(!data_oe_n) |-> !sclk)
    else $error("result bit changed while clock high");
  low_half_a: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
    else $error("shift clock low phase wrong");
  frame_start_a: assert property ($fell(frame_n) |-> sclk)
    else $error("frame opened with clock low");
  frame_end_a: assert property ($rose(frame_n) |-> sclk)
    else $error("frame closed with clock low");
  frame_gap_a: assert property ($rose(frame_n) |-> frame_n [*3])
    else $error("frame reopened too soon");
endmodule // sarrd_monitor

// File: sim/sar_adc_serial_readout_test.sv
// Purpose: bench joining host end and converter end over the link
// Assumes: host makes the link clock by its divider
// Notes:   codes are random from a fixed xorshift seed plus corner codes
`timescale 1ns/10ps
module sar_adc_serial_readout_test;
  import sarrd_pkg::*;
  logic         clk_i, sys_rst_i, start_i, cont_i, active_o, busy_o, result_vld_o;
  logic [3:0]   nbits_i;
  logic [11:0]  sample_i, held_code_o, result_o, code;
  logic [15:0]  wire_sh;
  logic [31:0]  rnd;
  logic [11:0]  corners [4] = '{12'h07ff, 12'h0800, 12'h0000, 12'h0fff};
  sarrd_phase_t phase_o;
  int           miscompares, n_checks, acq_n, k;
  sarrd_link_if sarrd_link_if_i ();
  sarrd_dev sarrd_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(sarrd_link_if_i.dev),
    .sample_i(sample_i), .active_o(active_o), .phase_o(phase_o), .held_code_o(held_code_o));
  sarrd_host sarrd_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(sarrd_link_if_i.host),
    .start_i(start_i), .cont_i(cont_i), .nbits_i(nbits_i), .busy_o(busy_o),
    .result_o(result_o), .result_vld_o(result_vld_o));
  sarrd_monitor sarrd_monitor_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .frame_n(sarrd_link_if_i.frame_n), .sclk(sarrd_link_if_i.sclk),
    .data(sarrd_link_if_i.data), .data_oe_n(sarrd_link_if_i.data_oe_n));
  // clock generator
  initial begin
    clk_i = 1'b0;
    forever #(SYS_CLK_NS / 2) clk_i = ~clk_i;
  end
  // wire capture on shift-clock rises and acquisition time count
  always @(posedge sarrd_link_if_i.sclk) if (!sarrd_link_if_i.frame_n)
    wire_sh <= {wire_sh[14:0], sarrd_link_if_i.data};
  always @(posedge clk_i) if (phase_o === SARRD_ACQ) acq_n++;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // bits kept when only n result bits are read
  function automatic logic [11:0] top_mask(input int n);
    return ~(12'h0fff >> n);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // wait for a result; in single frames disturb the input once converting
  task automatic wait_vld(input logic [11:0] c);
    int i;
    for (i = 0; i < 400 && result_vld_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
      if (phase_o === SARRD_CONV && cont_i === 1'b0) sample_i = ~c;
    end
    if (i == 400) check(16'h0001, 16'h0000);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 400 && busy_o !== 1'b0; i++) @(posedge clk_i);
    if (i == 400) check(16'h0001, 16'h0000);
    #1;
  endtask
  // one frame reading n bits of code c
  task automatic frame(input logic [11:0] c, input logic [3:0] n);
    int i;
    wait_idle();
    sample_i = c;
    nbits_i = n;
    start_i = 1'b1;
    acq_n = 0;
    wait_vld(c);
    start_i = 1'b0;
    check({4'h0, result_o & top_mask(n)}, {4'h0, c & top_mask(n)});
    check({4'h0, held_code_o}, {4'h0, c});
    if (n == 4'hc) check(wire_sh, {4'h0, c});
    check(16'(acq_n), 16'(ACQ_CYCLES * 2 * HALF_DIV));
    for (i = 0; i < 40 && sarrd_link_if_i.data_oe_n !== 1'b1; i++) @(posedge clk_i);
    #1;
    check({15'h0, sarrd_link_if_i.data_oe_n}, 16'h0001);
    check({15'h0, active_o}, 16'h0000);
  endtask
  // watchdog
  initial begin
    #2_000_000;
    miscompares++;
    print_verdict();
  end
  // main sequence: corners, short frames, random frames, continuous run
  initial begin
    sys_rst_i = 1'b1;
    {start_i, cont_i, nbits_i, sample_i, rnd, acq_n} = {6'h00, 12'h000, 32'hdff7, 32'h0};
    repeat (2) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    foreach (corners[j]) frame(corners[j], 4'hc);
    for (k = 1; k < 12; k++) begin
      rnd = xs(rnd);
      frame(rnd[11:0], 4'(k));
    end
    repeat (12) begin
      rnd = xs(rnd);
      frame(rnd[11:0], 4'hc);
    end
    wait_idle();
    code = 12'h0123;
    {sample_i, cont_i, nbits_i, start_i} = {code, 1'b1, 4'hc, 1'b1};
    repeat (4) begin
      wait_vld(code);
      check({4'h0, result_o}, {4'h0, code});
      check({15'h0, sarrd_link_if_i.frame_n}, 16'h0000);
      rnd = xs(rnd);
      code = rnd[11:0];
      sample_i = code;
      start_i = 1'b0;
      @(posedge clk_i);
      #1;
    end
    cont_i = 1'b0;
    wait_idle();
    print_verdict();
  end
endmodule // sar_adc_serial_readout_test
